// file: src/ctm_defines.svh
// register indices, field positions and reset values of the capture timer
// assumes a word-addressed bus: byte address is four times the index
`ifndef CTM_DEFINES_SVH
`define CTM_DEFINES_SVH

// ****************
// register indices
// ****************
`define CTM_IDX_CTRL    3'h0
`define CTM_IDX_STAT    3'h1
`define CTM_IDX_IRQEN   3'h2
`define CTM_IDX_COUNT   3'h3
`define CTM_IDX_COMPARE 3'h4
`define CTM_IDX_CAPTURE 3'h5
`define CTM_IDX_LOWER   3'h6

// ****************
// control fields
// ****************
`define CTM_CKS_LO      0
`define CTM_CKS_HI      2
`define CTM_MDS_BIT     3
`define CTM_EDGE_BIT    4
`define CTM_START_BIT   5
`define CTM_CTRL_W      6
`define CTM_CKS_EXT     3'h7
`define CTM_DIV_MIN_LOG 4'h1
`define CTM_DIV_LOG_OFS 4'h2

// ****************
// status fields
// ****************
`define CTM_FLG_WRAP    0
`define CTM_FLG_CMP     1
`define CTM_FLG_CAP     2
`define CTM_FLG_UP      3
`define CTM_FLG_LOW     4
`define CTM_NFLAGS      5
`define CTM_POLIN_BIT   5
`define CTM_POLGATE_BIT 6

// ****************
// interrupt enable fields
// ****************
`define CTM_IE_WRAP     7
`define CTM_IE_UP       6
`define CTM_IE_CMP      5
`define CTM_IE_PIN      4
`define CTM_IE_CAP      3
`define CTM_IE_LOW      2
`define CTM_IE_GSEL     1

// ****************
// reset values
// ****************
`define CTM_RST_CMP     16'hFFFF
`define CTM_RST_LOW     16'h0000
`define CTM_CNT_MAX     16'hFFFF

`endif

// file: src/ctm_pkg.sv
// types shared by the capture timer files
// assumes ctm_defines.svh for numeric constants
package ctm_pkg;
  typedef enum logic [1:0] {
    CTM_MEAS_WAIT = 2'b01,
    CTM_MEAS_RUN  = 2'b10
  } ctm_meas_t;
  typedef logic [15:0] ctm_word_t;
endpackage : ctm_pkg

// file: src/ctm_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pins; output changes once stages two and three agree
`timescale 1ns/10ps
module ctm_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinLvl
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] lvl_r;

  // stage one feeds stage two only; a level counts when two and three agree
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        s1_r[i]  <= 1'b0;
        s2_r[i]  <= 1'b0;
        s3_r[i]  <= 1'b0;
        lvl_r[i] <= 1'b0;
      end else begin
        s1_r[i] <= pinIn[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          lvl_r[i] <= s3_r[i];
        end
      end
    end
  end

  assign pinLvl = lvl_r;
endmodule : ctm_sync

// file: src/ctm_timer.sv
// 16-bit capture timer channel with Avalon-MM register slave
// assumes one 10 MHz clock, word addressing, pins asynchronous to sys_clk
//
// Notes on behaviour
// RULE1 - bit 7 gates counter wrap request
// RULE2 - bit 6 gates upper limit request
// RULE3 - bit 5 gates compare match request
// RULE4 - bit 4 enables event pin input
// RULE5 - software changes pin/gate bits only stopped
// RULE6 - bit 3 gates capture request
// RULE7 - bit 2 gates lower limit request
// RULE8 - gate select 0 measures continuously
// RULE9 - gate select 1 measures on gate level
// RULE10 - enable bit 0 reads zero, ignores writes
// RULE11 - reset gives timer mode, enables zero
// RULE12 - mode bit picks timer or measurement
// RULE13 - counter counts only while start set; measurement mode counts whatever the start bit
// RULE14 - wrap from all ones sets flag
// RULE15 - external clock pulses at least 1.5 cycles
// RULE16 - selected edge captures count, sets flag
// RULE17 - edge select picks capture edge
// RULE18 - compare flag set leaving match state
// RULE19 - polarity bit reverses edge select
// RULE20 - clock select divides or picks external
// RULE21 - request follows flag and enable
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
`include "ctm_defines.svh"
module ctm_timer (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic [2:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  input  wire logic             eventInputPin,
  input  wire logic             measureGateInput,
  input  wire logic             extClockPin,
  output ctm_pkg::ctm_word_t    captureValue,
  output logic                  overflowReq,
  output logic                  upperLimitReq,
  output logic                  compareReq,
  output logic                  captureReq,
  output logic                  lowerLimitRequest
);
  import ctm_pkg::*;

  // ****************
  // state
  // ****************
  logic [`CTM_CTRL_W-1:0]  ctrl_r;
  logic [7:1]              irqEn_r;
  logic                    polIn_r;
  logic                    polGate_r;
  logic [`CTM_NFLAGS-1:0]  flags_r;
  logic [`CTM_NFLAGS-1:0]  req_r;
  ctm_word_t               count_r;
  ctm_word_t               cmp_r;
  ctm_word_t               cap_r;
  ctm_word_t               low_r;
  logic [7:0]              presc_r;
  ctm_meas_t               meas_r;
  ctm_meas_t               meas_nxt;
  logic                    waitReq_r;
  logic [31:0]             rdData_r;
  logic [2:0]              prev_r;
  logic [2:0]              lvl;

  function automatic ctm_word_t merge16(input ctm_word_t old, input logic [31:0] wd, input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // ****************
  // pin synchronisers
  // ****************
  // narrow external clock pulses may be lost here RULE15
  ctm_sync #(.WIDTH(3)) uSync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .pinIn   ({extClockPin, measureGateInput, eventInputPin}),
    .pinLvl  (lvl)
  );

  // ****************
  // bus decode
  // ****************
  wire       busReq  = avs_read | avs_write;
  wire       wrDone  = avs_write & ~waitReq_r;
  wire       wrCtrl  = wrDone & (avs_address == `CTM_IDX_CTRL);
  wire       wrStat  = wrDone & (avs_address == `CTM_IDX_STAT);
  wire       wrIrqEn = wrDone & (avs_address == `CTM_IDX_IRQEN);
  wire       wrCount = wrDone & (avs_address == `CTM_IDX_COUNT);
  wire       wrCmp   = wrDone & (avs_address == `CTM_IDX_COMPARE);
  wire       wrLow   = wrDone & (avs_address == `CTM_IDX_LOWER);
  wire [4:0] flagClr = (wrStat & avs_byteenable[0]) ? avs_writedata[`CTM_NFLAGS-1:0] : 5'h00;
  wire [31:0] statRd = {25'h0000000, polGate_r, polIn_r, flags_r};
  // bit 0 of the enable register reads as zero RULE10
  wire [31:0] ieRd   = {24'h000000, irqEn_r, 1'b0};
  wire [31:0] rdMux  = (avs_address == `CTM_IDX_CTRL)    ? {26'h0000000, ctrl_r} :
                       (avs_address == `CTM_IDX_STAT)    ? statRd :
                       (avs_address == `CTM_IDX_IRQEN)   ? ieRd :
                       (avs_address == `CTM_IDX_COUNT)   ? {16'h0000, count_r} :
                       (avs_address == `CTM_IDX_COMPARE) ? {16'h0000, cmp_r} :
                       (avs_address == `CTM_IDX_CAPTURE) ? {16'h0000, cap_r} :
                       (avs_address == `CTM_IDX_LOWER)   ? {16'h0000, low_r} : 32'h00000000;

  // ****************
  // control decode
  // ****************
  wire [2:0] clkSel    = ctrl_r[`CTM_CKS_HI:`CTM_CKS_LO];
  wire       timerMode = ~ctrl_r[`CTM_MDS_BIT];                                          // RULE12
  wire       pinEn     = irqEn_r[`CTM_IE_PIN];
  wire       gateSel   = irqEn_r[`CTM_IE_GSEL];
  // divisor 2 for code 0, else 2 to the power code+2
  wire [3:0] divLog    = (clkSel == 3'h0) ? `CTM_DIV_MIN_LOG : ({1'b0, clkSel} + `CTM_DIV_LOG_OFS); // RULE20
  wire [7:0] divMask   = ~(8'hFF << divLog);
  wire       intTick   = (presc_r & divMask) == divMask;
  wire       extTick   = lvl[2] & ~prev_r[2];
  wire       tick      = (clkSel == `CTM_CKS_EXT) ? extTick : intTick;                  // RULE20

  // ****************
  // event and gate
  // ****************
  // the pin is masked before edge detection RULE4
  wire       evNow     = pinEn & (lvl[0] ^ polIn_r);
  wire       evPrev    = pinEn & (prev_r[0] ^ polIn_r);
  wire       selEdge   = ctrl_r[`CTM_EDGE_BIT] ? (evPrev & ~evNow) : (evNow & ~evPrev); // RULE17 RULE19
  wire       gateOk    = ~gateSel | (lvl[1] == polGate_r);                              // RULE8 RULE9
  wire       measEdge  = ~timerMode & selEdge & gateOk;
  wire       measRun   = meas_r == CTM_MEAS_RUN;

  // ****************
  // counter events
  // ****************
  wire       cntEn     = timerMode ? (ctrl_r[`CTM_START_BIT] & tick) : (tick & gateOk); // RULE13
  wire       measClr   = measEdge;
  wire       measCap   = measEdge & measRun;
  wire       wrapSet   = cntEn & (count_r == `CTM_CNT_MAX);                             // RULE14
  // flag rises on the tick that leaves the matching value
  wire       cmpSet    = timerMode & cntEn & (count_r == cmp_r) & ~wrCmp;               // RULE18
  wire       capSet    = timerMode & selEdge;                                           // RULE16
  wire       upSet     = measCap & (count_r > cmp_r);
  wire       lowSet    = measCap & (count_r < low_r);
  wire [4:0] flagSet   = {lowSet, upSet, capSet, cmpSet, wrapSet};
  wire [4:0] flagEn    = {irqEn_r[`CTM_IE_LOW], irqEn_r[`CTM_IE_UP], irqEn_r[`CTM_IE_CAP],
                          irqEn_r[`CTM_IE_CMP], irqEn_r[`CTM_IE_WRAP]};

  // ****************
  // measurement state
  // ****************
  always_comb begin
    meas_nxt = meas_r;
    case (meas_r)
      CTM_MEAS_WAIT: begin
        if (measEdge) begin
          meas_nxt = CTM_MEAS_RUN;
        end
      end
      CTM_MEAS_RUN: begin
        if (timerMode) begin
          meas_nxt = CTM_MEAS_WAIT;
        end
      end
      default: begin
        meas_nxt = CTM_MEAS_WAIT;
      end
    endcase
  end

  // ****************
  // bus slave
  // ****************
  // one wait state: data is fetched while waitrequest is high
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      waitReq_r <= 1'b1;
      rdData_r  <= 32'h00000000;
    end else begin
      waitReq_r <= ~(busReq & waitReq_r);
      if (avs_read & waitReq_r) begin
        rdData_r <= rdMux;
      end
    end
  end

  // ****************
  // registers
  // ****************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r    <= '0;                                                                   // RULE11
      irqEn_r   <= '0;                                                                   // RULE11
      polIn_r   <= 1'b0;
      polGate_r <= 1'b0;
      cmp_r     <= `CTM_RST_CMP;
      low_r     <= `CTM_RST_LOW;
    end else begin
      if (wrCtrl & avs_byteenable[0]) begin
        ctrl_r <= avs_writedata[`CTM_CTRL_W-1:0];
      end
      if (wrIrqEn & avs_byteenable[0]) begin
        irqEn_r <= avs_writedata[7:1];                                                   // RULE10
      end
      if (wrStat & avs_byteenable[0]) begin
        polIn_r   <= avs_writedata[`CTM_POLIN_BIT];
        polGate_r <= avs_writedata[`CTM_POLGATE_BIT];
      end
      if (wrCmp) begin
        cmp_r <= merge16(cmp_r, avs_writedata, avs_byteenable);
      end
      if (wrLow) begin
        low_r <= merge16(low_r, avs_writedata, avs_byteenable);
      end
    end
  end

  // ****************
  // counter, capture, flags
  // ****************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      count_r <= 16'h0000;
      cap_r   <= 16'h0000;
      presc_r <= 8'h00;
      prev_r  <= 3'h0;
      meas_r  <= CTM_MEAS_WAIT;
      flags_r <= '0;
      req_r   <= '0;
    end else begin
      presc_r <= presc_r + 8'h01;
      prev_r  <= lvl;
      meas_r  <= meas_nxt;
      // a bus write wins over counting and over clearing
      if (wrCount) begin
        count_r <= merge16(count_r, avs_writedata, avs_byteenable);
      end else if (measClr) begin
        count_r <= 16'h0000;
      end else if (cntEn) begin
        count_r <= count_r + 16'h0001;                                                   // RULE13 RULE14
      end
      if (capSet | measCap) begin
        cap_r <= count_r;                                                                // RULE16
      end
      // set beats a same-cycle write-one clear
      flags_r <= (flags_r & ~flagClr) | flagSet;
      req_r   <= flags_r & flagEn;                                                       // RULE1 RULE2 RULE3 RULE6 RULE7 RULE21
    end
  end

  assign avs_readdata      = rdData_r;
  assign avs_waitrequest   = waitReq_r;
  assign captureValue      = cap_r;
  assign overflowReq       = req_r[`CTM_FLG_WRAP];
  assign compareReq        = req_r[`CTM_FLG_CMP];
  assign captureReq        = req_r[`CTM_FLG_CAP];
  assign upperLimitReq     = req_r[`CTM_FLG_UP];
  assign lowerLimitRequest = req_r[`CTM_FLG_LOW];

  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_wrap_req_gate: assert property (overflowReq == $past(flags_r[`CTM_FLG_WRAP] & irqEn_r[`CTM_IE_WRAP])) // RULE1
    else $error("overflow request does not follow flag and enable");
  a_up_req_gate: assert property (!$past(irqEn_r[`CTM_IE_UP]) |-> !upperLimitReq) // RULE2
    else $error("upper limit request while disabled");
  a_cmp_req_gate: assert property (compareReq |-> $past(flags_r[`CTM_FLG_CMP] & irqEn_r[`CTM_IE_CMP])) // RULE3
    else $error("compare request without flag and enable");
  a_pin_ignored: assert property (!pinEn |-> !capSet && !measEdge) // RULE4
    else $error("event pin acted while disabled");
  a_cap_req_gate: assert property (captureReq == $past(flags_r[`CTM_FLG_CAP] & irqEn_r[`CTM_IE_CAP])) // RULE6
    else $error("capture request mismatch");
  a_low_req_gate: assert property (lowerLimitRequest |-> $past(irqEn_r[`CTM_IE_LOW])) // RULE7
    else $error("lower limit request while disabled");
  a_gate_hold: assert property (gateSel && lvl[1] != polGate_r && !timerMode && !wrCount |=> // RULE9
                                count_r == $past(count_r))
    else $error("measurement counted while gate closed");
  a_count_stop: assert property (timerMode && !ctrl_r[`CTM_START_BIT] && !wrCount |=> // RULE13
                                 count_r == $past(count_r))
    else $error("counter moved while stopped");
  a_wrap_flag: assert property (wrapSet && !wrCount |=> count_r == 16'h0000 && flags_r[`CTM_FLG_WRAP]) // RULE14
    else $error("wrap did not clear count and set flag");
  a_capture_copy: assert property (capSet |=> cap_r == $past(count_r) && flags_r[`CTM_FLG_CAP]) // RULE16
    else $error("capture value or flag wrong");
  a_cmp_flag: assert property (cmpSet && !wrCount |=> // RULE18
                               flags_r[`CTM_FLG_CMP] && count_r == $past(cmp_r) + 16'h0001)
    else $error("compare flag not set on leaving match");
  a_bus_answer: assert property (busReq && waitReq_r |=> !waitReq_r ##1 waitReq_r)
    else $error("bus answer not one wait state");
  // in measurement mode with gating off every tick without a count write or measurement edge must count, whatever the gate pin does
  a_gate_free: assert property (!gateSel && !timerMode && tick && !wrCount && !measEdge |=> // RULE8
                                count_r == $past(count_r) + 16'h0001)
    else $error("measurement did not count with gating off");

  c_overflow: cover property (wrapSet ##1 overflowReq);
  c_capture:  cover property (capSet ##[1:2] captureReq);
  c_compare:  cover property (cmpSet);
  c_measure:  cover property (measCap && upSet);
  c_gated:    cover property (gateSel && !gateOk && tick && !timerMode);
endmodule : ctm_timer

// file: verif/capture_timer_irq_enable_timer_mode_bench.sv
// self-checking bench for the capture timer through its Avalon-MM slave
// assumes ctm_timer and ctm_pin_model are compiled first
`timescale 1ns/10ps
`include "ctm_defines.svh"
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); end end
module capture_timer_irq_enable_timer_mode_bench;
  import ctm_pkg::*;
  logic               sys_clk = 1'b0;
  logic               nrst = 1'b0;
  logic [2:0]         avs_address;
  logic               avs_read;
  logic               avs_write;
  logic [31:0]        avs_writedata;
  logic [3:0]         avs_byteenable;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic               eventInputPin, measureGateInput, extClockPin;
  ctm_word_t          captureValue;
  logic               overflowReq, upperLimitReq, compareReq, captureReq, lowerLimitRequest;
  logic [31:0]        q;
  logic               pol, edg, expRise;
  int                 n_errors = 0;
  int                 cmp_count = 0;
  logic [15:0]        rstVal [0:7] = '{16'h0, 16'h0, 16'h0, 16'h0, `CTM_RST_CMP, 16'h0, `CTM_RST_LOW, 16'h0};
  int                 dv;

  always #50 sys_clk = ~sys_clk;

  ctm_timer DUT (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .eventInputPin(eventInputPin),
    .measureGateInput(measureGateInput), .extClockPin(extClockPin), .captureValue(captureValue),
    .overflowReq(overflowReq), .upperLimitReq(upperLimitReq), .compareReq(compareReq),
    .captureReq(captureReq), .lowerLimitRequest(lowerLimitRequest));
  ctm_pin_model u_pins (.sys_clk(sys_clk), .eventInputPin(eventInputPin),
    .measureGateInput(measureGateInput), .extClockPin(extClockPin));

  // ****************
  // bus and report tasks
  // ****************
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  // one idle cycle after each access so no strobe is assigned twice in a time step
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    r = avs_readdata;
    if (n >= 50) begin
      n_errors++;
      end_of_test();
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, {16'h0, d}, dummy);
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  initial begin
    cyc(100000);
    n_errors++;
    end_of_test();
  end

  // ****************
  // main sequence
  // ****************
  initial begin
    avs_address    <= 3'h0;
    avs_read       <= 1'b0;
    avs_write      <= 1'b0;
    avs_writedata  <= 32'h0;
    avs_byteenable <= 4'hF;
    cyc(10);
    nrst <= 1'b1;
    cyc(2);
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], q);
      `CHK(q, {16'h0, rstVal[i]})
    end
    wr(`CTM_IDX_IRQEN, 16'h00FF);
    rd(`CTM_IDX_IRQEN, q);
    `CHK(q, 32'h0000_00FE)
    wr(3'h7, 16'hFFFF);
    $display("test reset and enable bits done");

    // wrap with its enable off, then on, then flag cleared
    wr(`CTM_IDX_IRQEN, 16'h0000);
    wr(`CTM_IDX_COUNT, 16'hFFF0);
    wr(`CTM_IDX_STAT, 16'h001F);
    wr(`CTM_IDX_CTRL, 16'h0020);
    cyc(60);
    rd(`CTM_IDX_STAT, q);
    `CHK(q[`CTM_FLG_WRAP], 1'b1)
    `CHK(overflowReq, 1'b0)
    wr(`CTM_IDX_IRQEN, 16'h0080);
    cyc(3);
    `CHK(overflowReq, 1'b1)
    wr(`CTM_IDX_STAT, 16'h0001);
    cyc(3);
    `CHK(overflowReq, 1'b0)
    $display("test counter wrap done");

    // the prescaler free runs, so allow one count of phase slack per window
    for (int c = 0; c < 7; c++) begin
      dv = 2 << (c == 0 ? 0 : c + 1);
      wr(`CTM_IDX_CTRL, c[15:0]);
      wr(`CTM_IDX_COUNT, 16'h0000);
      wr(`CTM_IDX_CTRL, 16'h0020 | c[15:0]);
      cyc(512);
      wr(`CTM_IDX_CTRL, c[15:0]);
      rd(`CTM_IDX_COUNT, q);
      `CHK(q >= 512 / dv && q <= 520 / dv + 1, 1'b1)
      cyc(20);
      rd(`CTM_IDX_COUNT, dv);
      `CHK(dv, q)
    end
    $display("test clock select done");

    // external clock: the flag must wait for the count to leave the match value
    wr(`CTM_IDX_COUNT, 16'h0000);
    // compare loaded one byte lane at a time
    avs_byteenable <= 4'h2;
    wr(`CTM_IDX_COMPARE, 16'h0000);
    avs_byteenable <= 4'h1;
    wr(`CTM_IDX_COMPARE, 16'h5503);
    avs_byteenable <= 4'hF;
    rd(`CTM_IDX_COMPARE, q);
    `CHK(q, 32'h0000_0003)
    wr(`CTM_IDX_STAT, 16'h001F);
    wr(`CTM_IDX_IRQEN, 16'h0020);
    wr(`CTM_IDX_CTRL, 16'h0027);
    u_pins.ext_pulses(3);
    cyc(10);
    rd(`CTM_IDX_COUNT, q);
    `CHK(q, 32'h0000_0003)
    rd(`CTM_IDX_STAT, q);
    `CHK(q[`CTM_FLG_CMP], 1'b0)
    u_pins.ext_pulses(1);
    cyc(10);
    rd(`CTM_IDX_STAT, q);
    `CHK(q[`CTM_FLG_CMP], 1'b1)
    `CHK(compareReq, 1'b1)
    wr(`CTM_IDX_IRQEN, 16'h0000);
    cyc(3);
    `CHK(compareReq, 1'b0)
    wr(`CTM_IDX_CTRL, 16'h0000);
    $display("test compare match done");

    // pin disabled: an edge must leave no trace
    wr(`CTM_IDX_IRQEN, 16'h0008);
    wr(`CTM_IDX_STAT, 16'h001F);
    u_pins.set_evt(1'b1);
    cyc(10);
    rd(`CTM_IDX_STAT, q);
    `CHK(q[`CTM_FLG_CAP], 1'b0)
    `CHK(captureReq, 1'b0)
    u_pins.set_evt(1'b0);
    cyc(10);
    wr(`CTM_IDX_IRQEN, 16'h0018);
    for (int k = 0; k < 4; k++) begin
      pol = k[1];
      edg = k[0];
      expRise = (pol == edg);
      wr(`CTM_IDX_STAT, {10'h0, pol, 5'h00});
      wr(`CTM_IDX_CTRL, {11'h0, edg, 4'h0});
      cyc(8);
      wr(`CTM_IDX_COUNT, 16'h1230 + k[15:0]);
      wr(`CTM_IDX_STAT, {10'h0, pol, 5'h1F});
      u_pins.set_evt(1'b1);
      cyc(10);
      rd(`CTM_IDX_STAT, q);
      `CHK(q[`CTM_FLG_CAP], expRise)
      `CHK(captureReq, expRise)
      wr(`CTM_IDX_STAT, {10'h0, pol, 5'h1F});
      u_pins.set_evt(1'b0);
      cyc(10);
      rd(`CTM_IDX_STAT, q);
      `CHK(q[`CTM_FLG_CAP], !expRise)
      `CHK(captureValue, 16'h1230 + k[15:0])
    end
    wr(`CTM_IDX_STAT, 16'h001F);
    $display("test input capture done");

    // measurement without gating: short period lies above upper and below lower limit
    wr(`CTM_IDX_CTRL, 16'h0000);
    wr(`CTM_IDX_IRQEN, 16'h0054);
    wr(`CTM_IDX_COMPARE, 16'h0005);
    wr(`CTM_IDX_LOWER, 16'h0100);
    wr(`CTM_IDX_COUNT, 16'h0000);
    wr(`CTM_IDX_STAT, 16'h001F);
    wr(`CTM_IDX_CTRL, 16'h0008);
    u_pins.evt_run(20, 8);
    cyc(10);
    rd(`CTM_IDX_STAT, q);
    `CHK(q[4:3], 2'b11)
    `CHK(upperLimitReq, 1'b1)
    `CHK(lowerLimitRequest, 1'b1)
    wr(`CTM_IDX_IRQEN, 16'h0010);
    cyc(3);
    `CHK({upperLimitReq, lowerLimitRequest}, 2'b00)
    $display("test cycle measurement done");

    // gated measurement: polarity 0 counts only while the gate is low
    wr(`CTM_IDX_CTRL, 16'h0000);
    wr(`CTM_IDX_IRQEN, 16'h0012);
    wr(`CTM_IDX_STAT, 16'h001F);
    u_pins.set_gate(1'b1);
    wr(`CTM_IDX_COUNT, 16'h0000);
    wr(`CTM_IDX_CTRL, 16'h0008);
    cyc(100);
    rd(`CTM_IDX_COUNT, q);
    `CHK(q, 32'h0)
    u_pins.set_gate(1'b0);
    cyc(100);
    rd(`CTM_IDX_COUNT, q);
    `CHK(q != 32'h0, 1'b1)
    wr(`CTM_IDX_CTRL, 16'h0000);
    // polarity 1 counts only while the gate is high
    wr(`CTM_IDX_STAT, 16'h005F);
    wr(`CTM_IDX_COUNT, 16'h0000);
    wr(`CTM_IDX_CTRL, 16'h0008);
    cyc(100);
    rd(`CTM_IDX_COUNT, q);
    `CHK(q, 32'h0)
    u_pins.set_gate(1'b1);
    cyc(100);
    rd(`CTM_IDX_COUNT, q);
    `CHK(q != 32'h0, 1'b1)
    $display("test gated measurement done");

    // a reset in mid-run returns timer mode with every enable cleared
    nrst <= 1'b0;
    cyc(3);
    nrst <= 1'b1;
    cyc(2);
    rd(`CTM_IDX_CTRL, q);
    `CHK(q, 32'h0)
    rd(`CTM_IDX_IRQEN, q);
    `CHK(q, 32'h0)
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule : capture_timer_irq_enable_timer_mode_bench

// file: verif/ctm_pin_model.sv
// model of the pins around the timer: event pin, gating pin, external count clock
// assumes the caller sits just after a rising sys_clk edge when it calls a task
`timescale 1ns/10ps
module ctm_pin_model (
  input  wire logic sys_clk,
  output logic      eventInputPin,
  output logic      measureGateInput,
  output logic      extClockPin
);
  initial begin
    eventInputPin    = 1'b0;
    measureGateInput = 1'b0;
    extClockPin      = 1'b0;
  end
  // ****************
  // pin drivers
  // ****************
  task automatic set_evt(input logic lvl);
    @(posedge sys_clk);
    eventInputPin <= lvl;
  endtask : set_evt
  task automatic set_gate(input logic lvl);
    @(posedge sys_clk);
    measureGateInput <= lvl;
  endtask : set_gate
  task automatic evt_run(input int half, input int toggles);
    repeat (toggles) begin
      repeat (half) @(posedge sys_clk);
      eventInputPin <= ~eventInputPin;
    end
  endtask : evt_run
  // high for three cycles and low for four between pulses, at least twice the minimum width
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      extClockPin <= 1'b1;
      repeat (3) @(posedge sys_clk);
      extClockPin <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
  endtask : ext_pulses
endmodule : ctm_pin_model
